//--- hw/tmsd_defines.vh
// Constants for the tube mill scrap, dump and mist sequencer.
// Assumes a 32-bit classic Wishbone slave with word-aligned registers.
`ifndef TMSD_DEFINES_VH
`define TMSD_DEFINES_VH

// Register byte offsets.
`define TMSD_REG_CTRL        8'h00
`define TMSD_REG_PART_LEN    8'h04
`define TMSD_REG_NEXT_LEN    8'h08
`define TMSD_REG_TEST_LEN    8'h0C
`define TMSD_REG_SENSOR_DIST 8'h10
`define TMSD_REG_DUMP_DELAY  8'h14
`define TMSD_REG_DUMP_DWELL  8'h18
`define TMSD_REG_MIST_COUNT  8'h1C
`define TMSD_REG_MIST_DELAY  8'h20
`define TMSD_REG_MIST_DWELL  8'h24
`define TMSD_REG_STATUS      8'h28

// Control register fields.
`define TMSD_CTRL_RUN        0
`define TMSD_CTRL_CONT_FLOW  1
`define TMSD_CTRL_TEST_REQ   4
`define TMSD_CTRL_SET_NEXT   5
`define TMSD_CTRL_MAN_SHEAR  6

// Status register fields.
`define TMSD_STAT_RUN        0
`define TMSD_STAT_CUR_SCRAP  1
`define TMSD_STAT_TRIGGER    2
`define TMSD_STAT_MIST       3
`define TMSD_STAT_IGNORE     4
`define TMSD_STAT_FILL_INIT  5
`define TMSD_STAT_COUNT_LSB  8

// Reset values.
`define TMSD_RST_LEN         16'h0100
`define TMSD_RST_TEST_LEN    16'h0040
`define TMSD_RST_REF_LEN     16'h0010
`define TMSD_RST_TIME        16'h0064
`define TMSD_RST_MIST_COUNT  16'h0001

// Timing: timers count in milliseconds at a 125 MHz clock.
`define TMSD_CLK_PERIOD_NS   8
`define TMSD_TICK_NS         1000000

`endif

//--- hw/tmsd_seq.v
// Tube mill sequencer: part queue with scrap tracking, dump table and mister.
// Assumes synchronous sensor inputs, one encoder pulse per length unit,
// and a classic Wishbone master for configuration.
//
// Decided for this implementation: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
`include "tmsd_defines.vh"

// Operation
// - Scrap sensor marks bad material sections
// - Test request queues one scrap test part
// - Run set-next applies new length immediately
// - Continuous flow: auto crop on run entry
// - Continuous flow: idle manual homes, run ignored
// - No continuous flow: no crop, normal shear
// - Run starts empty, reference cut if moving
// - Entry fill class follows scrap input
// - Fill until a part is under sensor
// - Mark part, ignore sensor until end/halt
// - Two dump outputs: trigger and selector
// - Selector follows part, frozen during trigger
// - Dump delay after shear dwell, then dwell
// - Mist counter preset so first shear mists
// - Mist delay from shear on, then dwell
// - Mist count zero disables mister
// - Sensor distance zero disables scrap tracking
module tmsd_seq #(
    parameter TICK_CYC = `TMSD_TICK_NS / `TMSD_CLK_PERIOD_NS
) (
    input wire i_core_clk,
    input wire i_arst_n,
    input wire i_wb_cyc,
    input wire i_wb_stb,
    input wire i_wb_we,
    input wire [7:0] i_wb_adr,
    input wire [3:0] i_wb_sel,
    input wire [31:0] i_wb_dat,
    output reg [31:0] o_wb_dat,
    output reg o_wb_ack,
    input wire i_scrap_sensor,
    input wire i_shear_out,
    input wire i_enc_pulse,
    input wire i_line_moving,
    output reg o_auto_crop,
    output reg o_shear_req,
    output reg o_home_req,
    output reg o_dump_trigger,
    output reg o_scrap_sel,
    output reg o_mist
);

    localparam T_IDLE = 2'd0;
    localparam T_DELAY = 2'd1;
    localparam T_DWELL = 2'd2;

    reg [15:0] ctrl_q;
    reg [15:0] part_len_q;
    reg [15:0] next_len_q;
    reg [15:0] test_len_q;
    reg [15:0] dist_q;
    reg [15:0] dump_delay_q;
    reg [15:0] dump_dwell_q;
    reg [15:0] mist_count_q;
    reg [15:0] mist_delay_q;
    reg [15:0] mist_dwell_q;
    reg next_pend_q;

    reg [23:0] ent_end [0:7];
    reg ent_scr [0:7];
    reg [2:0] head_q;
    reg [3:0] count_q;
    reg [23:0] pos_q;
    reg run_q;
    reg shear_q;
    reg ref_pend_q;
    reg fill_init_q;
    reg init_class_q;
    reg ignore_q;
    reg [23:0] ign_end_q;
    reg cur_scrap_q;

    reg test_req_q;
    reg set_next_q;
    reg man_req_q;

    reg [16:0] tick_q;
    reg tick;
    reg [1:0] dump_st_q;
    reg [15:0] dump_cnt_q;
    reg [1:0] mist_st_q;
    reg [15:0] mist_cnt_q;
    reg [15:0] mist_left_q;

    wire bus_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
    wire bus_wr = bus_req & i_wb_we;
    wire run_req = ctrl_q[`TMSD_CTRL_RUN];
    wire cont_flow = ctrl_q[`TMSD_CTRL_CONT_FLOW];
    wire run_entry = run_req & ~run_q;
    wire shear_rise = i_shear_out & ~shear_q;
    wire shear_fall = ~i_shear_out & shear_q;
    wire tracking = (dist_q != 16'h0000);
    wire [23:0] sens_pos = pos_q + {8'h00, dist_q};
    wire [2:0] tail = head_q + count_q[2:0];

    function [2:0] ring_idx;
        input [2:0] base;
        input [3:0] off;
        begin
            ring_idx = base + off[2:0];
        end
    endfunction

    function [15:0] wr_half;
        input [15:0] old;
        input [31:0] dat;
        input [3:0] sel;
        begin
            wr_half[7:0] = sel[0] ? dat[7:0] : old[7:0];
            wr_half[15:8] = sel[1] ? dat[15:8] : old[15:8];
        end
    endfunction

    // Search for the oldest part whose end lies upstream of the sensor.
    reg under_found;
    reg [2:0] under_idx;
    reg [23:0] tail_end;
    integer i;
    always @* begin
        under_found = 1'b0;
        under_idx = 3'd0;
        for (i = 0; i < 8; i = i + 1) begin
            if (!under_found && (i < count_q) &&
                (ent_end[ring_idx(head_q, i[3:0])] > sens_pos)) begin
                under_found = 1'b1;
                under_idx = ring_idx(head_q, i[3:0]);
            end
        end
        tail_end = (count_q != 4'd0) ? ent_end[tail - 3'd1] : pos_q;
    end

    // Push selection: test part, then reference cut, then normal fill.
    reg push;
    reg [15:0] push_len;
    reg push_scr;
    reg fill_need;
    always @* begin
        push = 1'b0;
        push_len = part_len_q;
        push_scr = fill_init_q & init_class_q;
        fill_need = tracking ? (tail_end <= sens_pos) : (count_q == 4'd0);
        if (run_q && !run_entry && count_q < 4'd8) begin
            if (test_req_q) begin
                push = 1'b1;
                push_len = test_len_q;
                push_scr = 1'b1;
            end else if (ref_pend_q) begin
                push = 1'b1;
                push_len = `TMSD_RST_REF_LEN;
            end else if (fill_need) begin
                push = 1'b1;
            end
        end
    end

    wire pop = shear_rise & (count_q != 4'd0);
    wire sample_ok = run_q & tracking & ~ignore_q & under_found;

    // Wishbone slave, answers one cycle after the request.
    always @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= 32'h00000000;
            ctrl_q <= 16'h0000;
            part_len_q <= `TMSD_RST_LEN;
            next_len_q <= `TMSD_RST_LEN;
            test_len_q <= `TMSD_RST_TEST_LEN;
            dist_q <= 16'h0000;
            dump_delay_q <= `TMSD_RST_TIME;
            dump_dwell_q <= `TMSD_RST_TIME;
            mist_count_q <= `TMSD_RST_MIST_COUNT;
            mist_delay_q <= `TMSD_RST_TIME;
            mist_dwell_q <= `TMSD_RST_TIME;
            test_req_q <= 1'b0;
            set_next_q <= 1'b0;
            man_req_q <= 1'b0;
        end else begin
            o_wb_ack <= bus_req;
            test_req_q <= 1'b0;
            set_next_q <= 1'b0;
            man_req_q <= 1'b0;
            o_wb_dat <= 32'h00000000;
            if (set_next_q && run_q) begin
                part_len_q <= next_len_q;
            end
            if (bus_wr) begin
                case (i_wb_adr)
                    `TMSD_REG_CTRL: begin
                        if (i_wb_sel[0]) begin
                            ctrl_q[1:0] <= i_wb_dat[1:0];
                            test_req_q <= i_wb_dat[`TMSD_CTRL_TEST_REQ];
                            set_next_q <= i_wb_dat[`TMSD_CTRL_SET_NEXT];
                            man_req_q <= i_wb_dat[`TMSD_CTRL_MAN_SHEAR];
                        end
                    end
                    `TMSD_REG_PART_LEN:
                        part_len_q <= wr_half(part_len_q, i_wb_dat, i_wb_sel);
                    `TMSD_REG_NEXT_LEN:
                        next_len_q <= wr_half(next_len_q, i_wb_dat, i_wb_sel);
                    `TMSD_REG_TEST_LEN:
                        test_len_q <= wr_half(test_len_q, i_wb_dat, i_wb_sel);
                    `TMSD_REG_SENSOR_DIST:
                        dist_q <= wr_half(dist_q, i_wb_dat, i_wb_sel);
                    `TMSD_REG_DUMP_DELAY:
                        dump_delay_q <= wr_half(dump_delay_q, i_wb_dat,
                            i_wb_sel);
                    `TMSD_REG_DUMP_DWELL:
                        dump_dwell_q <= wr_half(dump_dwell_q, i_wb_dat,
                            i_wb_sel);
                    `TMSD_REG_MIST_COUNT:
                        mist_count_q <= wr_half(mist_count_q, i_wb_dat,
                            i_wb_sel);
                    `TMSD_REG_MIST_DELAY:
                        mist_delay_q <= wr_half(mist_delay_q, i_wb_dat,
                            i_wb_sel);
                    `TMSD_REG_MIST_DWELL:
                        mist_dwell_q <= wr_half(mist_dwell_q, i_wb_dat,
                            i_wb_sel);
                    default: begin
                    end
                endcase
            end else if (bus_req) begin
                case (i_wb_adr)
                    `TMSD_REG_CTRL: o_wb_dat <= {16'h0000, ctrl_q};
                    `TMSD_REG_PART_LEN: o_wb_dat <= {16'h0000, part_len_q};
                    `TMSD_REG_NEXT_LEN: o_wb_dat <= {16'h0000, next_len_q};
                    `TMSD_REG_TEST_LEN: o_wb_dat <= {16'h0000, test_len_q};
                    `TMSD_REG_SENSOR_DIST: o_wb_dat <= {16'h0000, dist_q};
                    `TMSD_REG_DUMP_DELAY:
                        o_wb_dat <= {16'h0000, dump_delay_q};
                    `TMSD_REG_DUMP_DWELL:
                        o_wb_dat <= {16'h0000, dump_dwell_q};
                    `TMSD_REG_MIST_COUNT:
                        o_wb_dat <= {16'h0000, mist_count_q};
                    `TMSD_REG_MIST_DELAY:
                        o_wb_dat <= {16'h0000, mist_delay_q};
                    `TMSD_REG_MIST_DWELL:
                        o_wb_dat <= {16'h0000, mist_dwell_q};
                    `TMSD_REG_STATUS:
                        o_wb_dat <= {20'h00000, count_q, 2'b00, fill_init_q,
                            ignore_q, o_mist, o_dump_trigger, cur_scrap_q,
                            run_q};
                    default: o_wb_dat <= 32'h00000000;
                endcase
            end
        end
    end

    // Part queue, material position and scrap tracking.
    always @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            head_q <= 3'd0;
            count_q <= 4'd0;
            pos_q <= 24'h000000;
            run_q <= 1'b0;
            shear_q <= 1'b0;
            ref_pend_q <= 1'b0;
            fill_init_q <= 1'b0;
            init_class_q <= 1'b0;
            ignore_q <= 1'b0;
            ign_end_q <= 24'h000000;
            cur_scrap_q <= 1'b0;
            next_pend_q <= 1'b0;
            o_auto_crop <= 1'b0;
            o_shear_req <= 1'b0;
            o_home_req <= 1'b0;
        end else begin
            run_q <= run_req;
            shear_q <= i_shear_out;
            o_auto_crop <= 1'b0;
            o_shear_req <= 1'b0;
            o_home_req <= 1'b0;
            if (i_enc_pulse) begin
                pos_q <= pos_q + 24'h000001;
            end
            if (set_next_q) begin
                if (!run_q) begin
                    next_pend_q <= 1'b1;
                end
            end
            if (man_req_q) begin
                if (cont_flow) begin
                    o_home_req <= ~run_q;
                end else begin
                    o_shear_req <= 1'b1;
                end
            end
            if (run_entry) begin
                count_q <= 4'd0;
                ref_pend_q <= i_line_moving;
                init_class_q <= i_scrap_sensor;
                fill_init_q <= 1'b1;
                ignore_q <= 1'b0;
                o_auto_crop <= cont_flow;
                if (next_pend_q) begin
                    next_pend_q <= 1'b0;
                end
            end else begin
                if (push) begin
                    ent_end[tail] <= tail_end + {8'h00, push_len};
                    ent_scr[tail] <= push_scr;
                    if (!test_req_q) begin
                        ref_pend_q <= 1'b0;
                    end
                end
                if (pop) begin
                    head_q <= head_q + 3'd1;
                end
                count_q <= count_q + {3'd0, push} - {3'd0, pop};
                if (under_found || !tracking) begin
                    fill_init_q <= 1'b0;
                end
                if (!run_q || !i_line_moving || sens_pos >= ign_end_q) begin
                    ignore_q <= 1'b0;
                end
                if (sample_ok && i_scrap_sensor) begin
                    ent_scr[under_idx] <= 1'b1;
                    ignore_q <= 1'b1;
                    ign_end_q <= ent_end[under_idx];
                end
            end
            if (shear_rise) begin
                cur_scrap_q <= (count_q != 4'd0) ? ent_scr[head_q] : 1'b0;
            end
        end
    end

    // Millisecond tick for the dump and mist timers.
    always @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            tick_q <= 17'd0;
            tick <= 1'b0;
        end else begin
            tick <= (tick_q == TICK_CYC[16:0] - 17'd1);
            if (tick_q == TICK_CYC[16:0] - 17'd1) begin
                tick_q <= 17'd0;
            end else begin
                tick_q <= tick_q + 17'd1;
            end
        end
    end

    // Dump table timing and selector.
    always @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            dump_st_q <= T_IDLE;
            dump_cnt_q <= 16'h0000;
            o_dump_trigger <= 1'b0;
            o_scrap_sel <= 1'b0;
        end else begin
            if (!o_dump_trigger) begin
                o_scrap_sel <= cur_scrap_q;
            end
            case (dump_st_q)
                T_IDLE: begin
                    if (shear_fall) begin
                        dump_st_q <= T_DELAY;
                        dump_cnt_q <= dump_delay_q;
                    end
                end
                T_DELAY: begin
                    if (dump_cnt_q == 16'h0000) begin
                        dump_st_q <= T_DWELL;
                        dump_cnt_q <= dump_dwell_q;
                        o_dump_trigger <= 1'b1;
                    end else if (tick) begin
                        dump_cnt_q <= dump_cnt_q - 16'h0001;
                    end
                end
                T_DWELL: begin
                    if (dump_cnt_q == 16'h0000) begin
                        dump_st_q <= T_IDLE;
                        o_dump_trigger <= 1'b0;
                    end else if (tick) begin
                        dump_cnt_q <= dump_cnt_q - 16'h0001;
                    end
                end
                default: dump_st_q <= T_IDLE;
            endcase
        end
    end

    // Mister: shear cycle counter, delay and dwell.
    always @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            mist_left_q <= 16'h0001;
            mist_st_q <= T_IDLE;
            mist_cnt_q <= 16'h0000;
            o_mist <= 1'b0;
        end else begin
            if (mist_count_q == 16'h0000) begin
                mist_st_q <= T_IDLE;
                o_mist <= 1'b0;
            end else begin
                if (shear_rise) begin
                    if (mist_left_q <= 16'h0001) begin
                        mist_left_q <= mist_count_q;
                        mist_st_q <= T_DELAY;
                        mist_cnt_q <= mist_delay_q;
                        o_mist <= 1'b0;
                    end else begin
                        mist_left_q <= mist_left_q - 16'h0001;
                    end
                end else begin
                    case (mist_st_q)
                        T_IDLE: o_mist <= 1'b0;
                        T_DELAY: begin
                            if (mist_cnt_q == 16'h0000) begin
                                mist_st_q <= T_DWELL;
                                mist_cnt_q <= mist_dwell_q;
                                o_mist <= 1'b1;
                            end else if (tick) begin
                                mist_cnt_q <= mist_cnt_q - 16'h0001;
                            end
                        end
                        T_DWELL: begin
                            if (mist_cnt_q == 16'h0000) begin
                                mist_st_q <= T_IDLE;
                                o_mist <= 1'b0;
                            end else if (tick) begin
                                mist_cnt_q <= mist_cnt_q - 16'h0001;
                            end
                        end
                        default: mist_st_q <= T_IDLE;
                    endcase
                end
            end
        end
    end

endmodule

//--- test/tmsd_seq_properties.sv
// Checker for the tube mill sequencer, bound to the sequencer's ports.
// Assumes CTRL and mist count are written with the low byte lane enabled.
`timescale 1ns/1ps
`include "tmsd_defines.vh"
module tmsd_seq_checker #(
    parameter TICK_CYC = 4
) (
    input wire i_core_clk,
    input wire i_arst_n,
    input wire i_wb_cyc,
    input wire i_wb_stb,
    input wire i_wb_we,
    input wire [7:0] i_wb_adr,
    input wire [31:0] i_wb_dat,
    input wire o_wb_ack,
    input wire i_shear_out,
    input wire o_auto_crop,
    input wire o_shear_req,
    input wire o_home_req,
    input wire o_dump_trigger,
    input wire o_scrap_sel,
    input wire o_mist
);
    reg run_q;
    reg flow_q;
    reg mist_off_q;
    wire wr_take = i_wb_cyc && i_wb_stb && i_wb_we && !o_wb_ack;
    // Shadow of the mode bits and of a zero mist count.
    always @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            run_q <= 1'b0;
            flow_q <= 1'b0;
            mist_off_q <= 1'b0;
        end else if (wr_take && i_wb_adr == `TMSD_REG_CTRL) begin
            run_q <= i_wb_dat[`TMSD_CTRL_RUN];
            flow_q <= i_wb_dat[`TMSD_CTRL_CONT_FLOW];
        end else if (wr_take && i_wb_adr == `TMSD_REG_MIST_COUNT) begin
            mist_off_q <= (i_wb_dat[15:0] == 16'h0000);
        end
    end
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_arst_n);
    property p_sel_frozen;
        o_dump_trigger |=> $stable(o_scrap_sel);
    endproperty
    a_sel_frozen: assert property (p_sel_frozen)
        else $error("Scrap selector moved while the trigger was on.");
    property p_mist_off;
        mist_off_q |-> !$rose(o_mist);
    endproperty
    a_mist_off: assert property (p_mist_off)
        else $error("Mist started with a zero mist count.");
    property p_home_idle;
        o_home_req |-> flow_q && !run_q;
    endproperty
    a_home_idle: assert property (p_home_idle)
        else $error("Home request outside idle continuous flow.");
    property p_shear_noflow;
        o_shear_req |-> !flow_q;
    endproperty
    a_shear_noflow: assert property (p_shear_noflow)
        else $error("Manual shear issued with continuous flow on.");
    property p_crop_flow;
        o_auto_crop |-> flow_q && run_q;
    endproperty
    a_crop_flow: assert property (p_crop_flow)
        else $error("Auto crop outside run with continuous flow.");
    property p_crop_entry;
        $rose(run_q) && flow_q |-> ##[1:2] o_auto_crop;
    endproperty
    a_crop_entry: assert property (p_crop_entry)
        else $error("No auto crop after run entry.");
    property p_dump_dwell;
        $rose(o_dump_trigger) |=> o_dump_trigger [*3];
    endproperty
    a_dump_dwell: assert property (p_dump_dwell)
        else $error("Dump trigger dropped before its dwell.");
    property p_dump_after;
        $rose(o_dump_trigger) |-> !i_shear_out;
    endproperty
    a_dump_after: assert property (p_dump_after)
        else $error("Dump trigger rose during shear dwell.");
    property p_mist_dwell;
        $rose(o_mist) |=> o_mist [*3];
    endproperty
    a_mist_dwell: assert property (p_mist_dwell)
        else $error("Mist dropped before its dwell.");
    c_mist: cover property ($rose(o_mist));
    c_dump: cover property ($rose(o_dump_trigger));
    c_home: cover property (o_home_req);
    c_crop: cover property (o_auto_crop);
endmodule

//--- test/tmsd_line_model.sv
// Line model: shear press, encoder and motion flag around the sequencer.
// Assumes fire commands are one-cycle pulses.
`timescale 1ns/1ps
module tmsd_line_model #(
    parameter [3:0] SHEAR_CYC = 4'h6
) (
    input wire i_clk,
    input wire i_rst_n,
    input wire i_fire,
    input wire i_move,
    output reg o_shear_out,
    output reg o_enc_pulse,
    output reg o_line_moving
);
    reg [3:0] cnt_q;
    // Shear holds for its dwell; encoder pulses every other cycle.
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_q <= 4'h0;
            o_shear_out <= 1'b0;
            o_enc_pulse <= 1'b0;
            o_line_moving <= 1'b0;
        end else begin
            if (i_fire && cnt_q == 4'h0)
                cnt_q <= SHEAR_CYC;
            else if (cnt_q != 4'h0)
                cnt_q <= cnt_q - 4'h1;
            o_shear_out <= (cnt_q != 4'h0);
            o_enc_pulse <= i_move && !o_enc_pulse;
            o_line_moving <= i_move;
        end
    end
endmodule

//--- test/tmsd_seq_tb.sv
// Self-checking bench for the tube mill sequencer.
// Assumes the sequencer acks each bus request and a 4-cycle timer tick.
`timescale 1ns/1ps
`include "tmsd_defines.vh"
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin \
    err_total++; $display("Error %s expected %0h seen %0h", nm, ex, got); \
    end end
module tb;
    localparam TICK = 4;
    logic core_clk, arst_n, wb_cyc, wb_stb, wb_we, wb_ack, scrap, fire;
    logic move_en, shear, enc, moving, crop, shear_req, home, trig, sel, mist;
    logic [7:0] wb_adr;
    logic [3:0] wb_sel;
    logic [31:0] wb_dat, rd_dat, seed, ex;
    logic [31:0] exp_q[$];
    int err_total, comparisons, cyc_n, t_sr, t_sf, t_mr, t_tr, h0, s0, c0;
    int mist_n, trig_n, home_n, shr_n, crop_n, m_lat, m_len, d_lat, d_len;
    logic p_sh, p_mi, p_tr;
    logic [31:0] rst_v[10] = '{32'h0, `TMSD_RST_LEN, `TMSD_RST_LEN,
        `TMSD_RST_TEST_LEN, 32'h0, `TMSD_RST_TIME, `TMSD_RST_TIME,
        `TMSD_RST_MIST_COUNT, `TMSD_RST_TIME, `TMSD_RST_TIME};
    logic [7:0] ctl[7] = '{8'h42, 8'h40, 8'h03, 8'h43, 8'h00, 8'h01, 8'h41};
    int dh[7] = '{1, 0, 0, 0, 0, 0, 0};
    int ds[7] = '{0, 1, 0, 0, 0, 0, 1};
    int dc[7] = '{0, 0, 1, 0, 0, 0, 0};
    wire fire_any = fire | shear_req | crop;
    tmsd_seq #(.TICK_CYC(TICK)) i_tmsd_seq (.i_core_clk(core_clk),
        .i_arst_n(arst_n), .i_wb_cyc(wb_cyc), .i_wb_stb(wb_stb),
        .i_wb_we(wb_we), .i_wb_adr(wb_adr), .i_wb_sel(wb_sel),
        .i_wb_dat(wb_dat), .o_wb_dat(rd_dat), .o_wb_ack(wb_ack),
        .i_scrap_sensor(scrap), .i_shear_out(shear), .i_enc_pulse(enc),
        .i_line_moving(moving), .o_auto_crop(crop), .o_shear_req(shear_req),
        .o_home_req(home), .o_dump_trigger(trig), .o_scrap_sel(sel),
        .o_mist(mist));
    tmsd_line_model i_tmsd_line_model (.i_clk(core_clk), .i_rst_n(arst_n),
        .i_fire(fire_any), .i_move(move_en), .o_shear_out(shear),
        .o_enc_pulse(enc), .o_line_moving(moving));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic tally_and_finish();
        $display("Comparisons %0d errors %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_adr <= a;
        wb_sel <= 4'h3;
        wb_dat <= d;
        do begin
            @(posedge core_clk);
            n++;
        end while (wb_ack !== 1'b1 && n < 20);
        if (n >= 20) err_total++;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        wb(a, 1'b0, 32'h0);
    endtask
    task automatic shot(input int gap);
        @(posedge core_clk);
        fire <= 1'b1;
        @(posedge core_clk);
        fire <= 1'b0;
        repeat (gap) @(posedge core_clk);
    endtask
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    // Takes read notes off the queue and measures output events.
    always @(posedge core_clk) begin
        cyc_n++;
        if (wb_ack === 1'b1 && !wb_we && exp_q.size() > 0) begin
            ex = exp_q.pop_front();
            `CHK("read data", ex, rd_dat)
        end
        if (shear && !p_sh) t_sr = cyc_n;
        if (!shear && p_sh) t_sf = cyc_n;
        if (mist && !p_mi) begin
            mist_n++;
            m_lat = cyc_n - t_sr;
            t_mr = cyc_n;
        end
        if (!mist && p_mi) m_len = cyc_n - t_mr;
        if (trig && !p_tr) begin
            trig_n++;
            d_lat = cyc_n - t_sf;
            t_tr = cyc_n;
        end
        if (!trig && p_tr) d_len = cyc_n - t_tr;
        home_n += home;
        shr_n += shear_req;
        crop_n += crop;
        p_sh = shear;
        p_mi = mist;
        p_tr = trig;
        if (cyc_n > 20000) begin
            err_total++;
            tally_and_finish();
        end
    end
    initial begin
        arst_n = 1'b0;
        {wb_cyc, wb_stb, wb_we, scrap, fire, move_en} = 6'h00;
        wb_adr = 8'h00;
        wb_sel = 4'h0;
        wb_dat = 32'h0;
        seed = 32'hF946727B;
        repeat (16) @(posedge core_clk);
        arst_n <= 1'b1;
        for (int i = 0; i < 10; i++) rd(8'(i * 4), rst_v[i]);
        rd(8'h3C, 32'h0);
        for (int i = 1; i < 4; i++) begin
            seed = lfsr(seed);
            wb(8'(i * 4), 1'b1, seed);
            rd(8'(i * 4), {16'h0, seed[15:0]});
        end
        wb(`TMSD_REG_DUMP_DELAY, 1'b1, 32'h3);
        wb(`TMSD_REG_DUMP_DWELL, 1'b1, 32'h2);
        wb(`TMSD_REG_MIST_COUNT, 1'b1, 32'h2);
        wb(`TMSD_REG_MIST_DELAY, 1'b1, 32'h2);
        wb(`TMSD_REG_MIST_DWELL, 1'b1, 32'h3);
        for (int k = 0; k < 3; k++) begin
            shot(80);
            `CHK("mists", (k + 2) / 2, mist_n)
            `CHK("mist delay", 1'b1, m_lat inside {[TICK+1:2*TICK+3]})
            `CHK("mist dwell", 1'b1, m_len inside {[2*TICK+1:3*TICK+3]})
            `CHK("dumps", k + 1, trig_n)
            `CHK("dump delay", 1'b1, d_lat inside {[2*TICK+1:3*TICK+3]})
            `CHK("dump dwell", 1'b1, d_len inside {[TICK+1:2*TICK+3]})
        end
        wb(`TMSD_REG_MIST_COUNT, 1'b1, 32'h0);
        shot(80);
        `CHK("mists off", 2, mist_n)
        for (int i = 0; i < 7; i++) begin
            h0 = home_n;
            s0 = shr_n;
            c0 = crop_n;
            wb(`TMSD_REG_CTRL, 1'b1, {24'h0, ctl[i]});
            repeat (40) @(posedge core_clk);
            `CHK("home", dh[i], home_n - h0)
            `CHK("manual shear", ds[i], shr_n - s0)
            `CHK("auto crop", dc[i], crop_n - c0)
        end
        rd(`TMSD_REG_CTRL, 32'h1);
        wb(`TMSD_REG_CTRL, 1'b1, 32'h0);
        wb(`TMSD_REG_SENSOR_DIST, 1'b1, 32'h4);
        wb(`TMSD_REG_PART_LEN, 1'b1, 32'h8);
        for (int s = 1; s >= 0; s--) begin
            scrap <= s[0];
            move_en <= 1'b1;
            wb(`TMSD_REG_CTRL, 1'b1, 32'h1);
            repeat (20) @(posedge core_clk);
            shot(6);
            `CHK("scrap select", s[0], sel)
            repeat (80) @(posedge core_clk);
            wb(`TMSD_REG_CTRL, 1'b1, 32'h0);
            move_en <= 1'b0;
        end
        tally_and_finish();
    end
endmodule
bind tmsd_seq tmsd_seq_checker #(.TICK_CYC(TICK_CYC)) i_tmsd_seq_checker (
    .i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_wb_cyc(i_wb_cyc),
    .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
    .i_wb_dat(i_wb_dat), .o_wb_ack(o_wb_ack), .i_shear_out(i_shear_out),
    .o_auto_crop(o_auto_crop), .o_shear_req(o_shear_req),
    .o_home_req(o_home_req), .o_dump_trigger(o_dump_trigger),
    .o_scrap_sel(o_scrap_sel), .o_mist(o_mist));
